// ### verilog/sba_cfg.svh
// Purpose: Constants for the system bus dual-issue arbiter.
// Assumes: Ten requesters, fixed index map.
// Notes: Index 0 is the processor, 1 the JTAG unit, then read/write pairs per DMA channel.
`ifndef SBA_CFG_SVH
`define SBA_CFG_SVH

`define SBA_NUM_MASTERS 10
`define SBA_NUM_DMA 4
`define SBA_IDX_W 4
`define SBA_IDX_CPU 4'h0
`define SBA_IDX_JTAG 4'h1
`define SBA_IDX_DMA_BASE 4'h2
`define SBA_IDX_LAST 4'h9
`define SBA_DMA_RD_MASK 10'h154
`define SBA_DMA_WR_MASK 10'h2a8
`define SBA_ADDR_ALWAYS 10'h003
`define SBA_VEC_RESET 10'h000
`define SBA_PTR_RESET 4'h0

`endif

// ### verilog/sba_pkg.sv
// Purpose: Types shared by the system bus arbiter files.
// Assumes: Widths from sba_cfg.svh.
// Notes: Types only; constants live in the header.
`include "sba_cfg.svh"

package sba_pkg;
  typedef logic [`SBA_NUM_MASTERS-1:0] sba_vec_t;
  typedef logic [`SBA_IDX_W-1:0] sba_idx_t;
endpackage : sba_pkg

// ### verilog/sba_rr_pick.sv
// Purpose: Round-robin search over the requester vector.
// Assumes: Pointer always below the requester count.
// Notes: Purely combinational; first set bit at or after the pointer wins.
`timescale 1ns/1ns
`include "sba_cfg.svh"

module sba_rr_pick
  import sba_pkg::*;
(
  // Search input
  input wire sba_vec_t mask,
  input wire sba_idx_t ptr,
  // Result
  output logic found,
  output sba_idx_t idx
);
  sba_idx_t j;

  always_comb begin
    found = 1'b0;
    idx = `SBA_IDX_CPU;
    j = ptr;
    for (int k = 0; k < `SBA_NUM_MASTERS; k++) begin
      if (!found && mask[j]) begin
        found = 1'b1;
        idx = j;
      end
      j = (j == `SBA_IDX_LAST) ? `SBA_IDX_CPU : sba_idx_t'(j + 4'h1);
    end
  end
endmodule : sba_rr_pick

// ### verilog/sba_arbiter.sv
// Purpose: Dual-issue round-robin arbiter for the on-chip system bus.
// Assumes: Requesters hold req until their grant cycle (and any wait-states) has ended.
// Notes: Two slots, read side and write side; the single address path goes to at most one of them.
`timescale 1ns/1ns
`include "sba_cfg.svh"

module sba_arbiter
  import sba_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Requests, one per master
  input wire sba_vec_t req,
  // Direction of processor and JTAG requests, high for write
  input wire logic cpu_wr,
  input wire logic jtag_wr,
  // DMA transfer kind per channel, high for addressed, low for acknowledge
  input wire logic [`SBA_NUM_DMA-1:0] dma_rd_addressed,
  input wire logic [`SBA_NUM_DMA-1:0] dma_wr_addressed,
  // Wait-state per data path for the current bus cycle
  input wire logic wait_rd,
  input wire logic wait_wr,
  // Grants
  output sba_vec_t rd_gnt,
  output sba_vec_t wr_gnt,
  output sba_vec_t addr_gnt,
  output logic paired
);
  sba_vec_t dir_wr;
  sba_vec_t needs_addr;
  sba_idx_t ptr;
  sba_idx_t next_ptr;
  sba_vec_t next_rd_gnt;
  sba_vec_t next_wr_gnt;
  sba_vec_t next_addr_gnt;
  logic next_paired;
  logic rd_hold;
  logic wr_hold;
  logic addr_busy;
  sba_vec_t cand;
  sba_vec_t elig_rd;
  sba_vec_t elig_wr;
  sba_vec_t first_mask;
  sba_vec_t second_mask;
  sba_vec_t first_oh;
  sba_vec_t second_oh;
  logic first_found;
  logic second_found;
  sba_idx_t first_idx;
  sba_idx_t second_idx;
  sba_vec_t behind_ptr;

  // Fixed requester attributes
  assign dir_wr[`SBA_IDX_CPU] = cpu_wr;
  assign dir_wr[`SBA_IDX_JTAG] = jtag_wr;
  assign needs_addr[`SBA_IDX_CPU] = 1'b1;
  assign needs_addr[`SBA_IDX_JTAG] = 1'b1;

  // Each DMA channel owns a separate read and write requester
  for (genvar c = 0; c < `SBA_NUM_DMA; c++) begin : g_dma
    assign dir_wr[2 + 2 * c] = 1'b0;
    assign dir_wr[3 + 2 * c] = 1'b1;
    assign needs_addr[2 + 2 * c] = dma_rd_addressed[c];
    assign needs_addr[3 + 2 * c] = dma_wr_addressed[c];
  end

  // A slot stays with its owner while its data path is waiting
  assign rd_hold = (|rd_gnt) && wait_rd;
  assign wr_hold = (|wr_gnt) && wait_wr;
  assign addr_busy = (rd_hold && |(rd_gnt & addr_gnt)) || (wr_hold && |(wr_gnt & addr_gnt));

  always_comb begin
    cand = req;
    if (rd_hold) begin
      cand = cand & ~rd_gnt;
    end
    if (wr_hold) begin
      cand = cand & ~wr_gnt;
    end
    elig_rd = rd_hold ? `SBA_VEC_RESET : (cand & ~dir_wr);
    elig_wr = wr_hold ? `SBA_VEC_RESET : (cand & dir_wr);
    if (addr_busy) begin
      elig_rd = elig_rd & ~needs_addr;
      elig_wr = elig_wr & ~needs_addr;
    end
    first_mask = elig_rd | elig_wr;
  end

  sba_rr_pick u_first (
    .mask(first_mask),
    .ptr(ptr),
    .found(first_found),
    .idx(first_idx)
  );

  always_comb begin
    first_oh = first_found ? sba_vec_t'(10'h001 << first_idx) : `SBA_VEC_RESET;
    // Partner must sit on the other data path
    second_mask = (|(first_oh & dir_wr)) ? elig_rd : elig_wr;
    // Only one of the pair may use the address path
    if (|(first_oh & needs_addr)) begin
      second_mask = second_mask & ~needs_addr;
    end
    if (!first_found) begin
      second_mask = `SBA_VEC_RESET;
    end
  end

  sba_rr_pick u_second (
    .mask(second_mask),
    .ptr(ptr),
    .found(second_found),
    .idx(second_idx)
  );

  always_comb begin
    second_oh = second_found ? sba_vec_t'(10'h001 << second_idx) : `SBA_VEC_RESET;
    next_rd_gnt = rd_hold ? rd_gnt : ((first_oh | second_oh) & ~dir_wr);
    next_wr_gnt = wr_hold ? wr_gnt : ((first_oh | second_oh) & dir_wr);
    next_addr_gnt = (next_rd_gnt | next_wr_gnt) & needs_addr;
    if (rd_hold) begin
      next_addr_gnt = (next_addr_gnt & ~rd_gnt) | (rd_gnt & addr_gnt);
    end
    if (wr_hold) begin
      next_addr_gnt = (next_addr_gnt & ~wr_gnt) | (wr_gnt & addr_gnt);
    end
    next_paired = (|next_rd_gnt) && (|next_wr_gnt);
    // Priority moves past the first-picked winner; the second pick does not move it
    next_ptr = ptr;
    if (first_found) begin
      next_ptr = (first_idx == `SBA_IDX_LAST) ? `SBA_IDX_CPU : sba_idx_t'(first_idx + 4'h1);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_gnt <= `SBA_VEC_RESET;
      wr_gnt <= `SBA_VEC_RESET;
      addr_gnt <= `SBA_VEC_RESET;
      paired <= 1'b0;
      ptr <= `SBA_PTR_RESET;
    end else begin
      rd_gnt <= next_rd_gnt;
      wr_gnt <= next_wr_gnt;
      addr_gnt <= next_addr_gnt;
      paired <= next_paired;
      ptr <= next_ptr;
    end
  end

  // Requester that the pointer has just moved past
  assign behind_ptr = (ptr == `SBA_PTR_RESET) ? sba_vec_t'(10'h001 << `SBA_IDX_LAST) :
    sba_vec_t'(10'h001 << (ptr - 4'h1));

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  property p_grant_requested;
    ((rd_gnt | wr_gnt) & ~$past(req)) == `SBA_VEC_RESET;
  endproperty
  a_grant_requested: assert property (p_grant_requested) else $error("grant to a non-requester");

  property p_one_address;
    $onehot0(addr_gnt) && ((addr_gnt & ~(rd_gnt | wr_gnt)) == `SBA_VEC_RESET);
  endproperty
  a_one_address: assert property (p_one_address) else $error("address path shared or orphaned");

  property p_opposite_paths;
    $onehot0(rd_gnt) && $onehot0(wr_gnt) && ((rd_gnt & wr_gnt) == `SBA_VEC_RESET) && (paired == (|rd_gnt && |wr_gnt));
  endproperty
  a_opposite_paths: assert property (p_opposite_paths) else $error("pairing not one read and one write");

  property p_cpu_jtag_addressed;
    ((rd_gnt | wr_gnt) & `SBA_ADDR_ALWAYS & ~addr_gnt) == `SBA_VEC_RESET;
  endproperty
  a_cpu_jtag_addressed: assert property (p_cpu_jtag_addressed) else $error("unaddressed CPU or JTAG");

  property p_dma_read_side;
    (rd_gnt & `SBA_DMA_WR_MASK) == `SBA_VEC_RESET;
  endproperty
  a_dma_read_side: assert property (p_dma_read_side) else $error("DMA write on read path");

  property p_dma_write_side;
    (wr_gnt & `SBA_DMA_RD_MASK) == `SBA_VEC_RESET;
  endproperty
  a_dma_write_side: assert property (p_dma_write_side) else $error("DMA read on write path");

  property p_dma_ack_no_addr;
    (|(rd_gnt & `SBA_DMA_RD_MASK) && !$past(rd_hold) && !(|(rd_gnt & addr_gnt))) |->
      ((rd_gnt & ($past(needs_addr))) == `SBA_VEC_RESET);
  endproperty
  a_dma_ack_no_addr: assert property (p_dma_ack_no_addr) else $error("addressed read granted without address");

  property p_hold_read;
    (|rd_gnt && wait_rd) |=> ($stable(rd_gnt) && ((rd_gnt & addr_gnt) == $past(rd_gnt & addr_gnt)));
  endproperty
  a_hold_read: assert property (p_hold_read) else $error("read slot dropped during wait");

  property p_hold_write;
    (|wr_gnt && wait_wr) |=> ($stable(wr_gnt) && ((wr_gnt & addr_gnt) == $past(wr_gnt & addr_gnt)));
  endproperty
  a_hold_write: assert property (p_hold_write) else $error("write slot dropped during wait");

  property p_ptr_range;
    (ptr <= `SBA_IDX_LAST) and
      ((|(rd_gnt | wr_gnt) && !$past(rd_hold) && !$past(wr_hold)) |-> |((rd_gnt | wr_gnt) & behind_ptr));
  endproperty
  a_ptr_range: assert property (p_ptr_range) else $error("priority pointer stuck or out of range");
endmodule : sba_arbiter

// ### tb/sba_masters.sv
// Purpose: Requester-side model for the system bus arbiter.
// Assumes: The bench posts requests between falling edges, never on one.
// Notes: Holds each request until its grant ends; can stall either data path.
`timescale 1ns/1ns

module sba_masters
  import sba_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Grants seen
  input wire sba_vec_t rd_gnt,
  input wire sba_vec_t wr_gnt,
  // Requests and stalls
  output sba_vec_t req,
  output logic wait_rd,
  output logic wait_wr
);
  sba_vec_t add = '0;
  int rd_left = 0;
  int wr_left = 0;
  logic nw_rd;
  logic nw_wr;

  task automatic post(input sba_vec_t v, input int rdw, input int wrw);
    add = add | v;
    rd_left = rdw;
    wr_left = wrw;
  endtask : post

  initial begin
    req = '0;
    wait_rd = 1'b0;
    wait_wr = 1'b0;
  end

  // A request is dropped only in the last cycle of its grant
  always @(negedge mclk) begin
    nw_rd = (rd_gnt != '0) && (rd_left > 0);
    nw_wr = (wr_gnt != '0) && (wr_left > 0);
    if (srst) begin
      req = '0;
    end else begin
      req = (req & ~((nw_rd ? '0 : rd_gnt) | (nw_wr ? '0 : wr_gnt))) | add;
    end
    wait_rd = nw_rd;
    wait_wr = nw_wr;
    rd_left = nw_rd ? rd_left - 1 : rd_left;
    wr_left = nw_wr ? wr_left - 1 : wr_left;
    add = '0;
  end
endmodule : sba_masters

// ### tb/testbench.sv
// Purpose: Self-checking bench for the system bus arbiter.
// Assumes: Requesters modelled by sba_masters.
// Notes: Each scenario checks grants one and more cycles after the request.
`timescale 1ns/1ns
`include "sba_cfg.svh"

module testbench;
  import sba_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cpu_wr = 1'b0;
  logic jtag_wr = 1'b0;
  logic [3:0] dra = 4'h0;
  logic [3:0] dwa = 4'h0;
  sba_vec_t req, rd_gnt, wr_gnt, addr_gnt, ur, uw;
  logic wait_rd, wait_wr, paired;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;

  initial forever #4 mclk = ~mclk;

  sba_arbiter sba_arbiter_inst (.mclk(mclk), .srst(srst), .req(req), .cpu_wr(cpu_wr), .jtag_wr(jtag_wr),
    .dma_rd_addressed(dra), .dma_wr_addressed(dwa), .wait_rd(wait_rd), .wait_wr(wait_wr),
    .rd_gnt(rd_gnt), .wr_gnt(wr_gnt), .addr_gnt(addr_gnt), .paired(paired));
  sba_masters sba_masters_inst (.mclk(mclk), .srst(srst), .rd_gnt(rd_gnt), .wr_gnt(wr_gnt),
    .req(req), .wait_rd(wait_rd), .wait_wr(wait_wr));

  task automatic finish_test;
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Post requests just after a rising edge; returns where the first grant is visible
  task automatic go(input sba_vec_t v, input logic cw, input logic jw, input logic [3:0] ra,
                    input logic [3:0] wa, input int rdw, input int wrw);
    @(posedge mclk);
    #1;
    sba_masters_inst.post(v, rdw, wrw);
    @(negedge mclk);
    cpu_wr = cw;
    jtag_wr = jw;
    dra = ra;
    dwa = wa;
    @(negedge mclk);
  endtask : go

  task automatic t_pair(input sba_vec_t v, input logic cw, input logic jw, input sba_vec_t rd,
                        input sba_vec_t wr, input sba_vec_t ad);
    go(v, cw, jw, 4'h0, 4'h0, 0, 0);
    cmp(rd_gnt, rd);
    cmp(wr_gnt, wr);
    cmp(addr_gnt, ad);
    cmp({9'h000, paired}, 10'h001);
    @(negedge mclk);
    cmp(rd_gnt | wr_gnt, 10'h000);
  endtask : t_pair

  task automatic t_two_addressed;
    ur = '0;
    go(10'h030, 1'b0, 1'b0, 4'h2, 4'h2, 0, 0);
    repeat (2) begin
      cmp({9'h000, paired}, 10'h000);
      cmp(addr_gnt, rd_gnt | wr_gnt);
      ur = ur | rd_gnt | wr_gnt;
      @(negedge mclk);
    end
    cmp(ur, 10'h030);
  endtask : t_two_addressed

  task automatic t_wait;
    go(10'h100, 1'b0, 1'b0, 4'h8, 4'h0, 1, 0);
    repeat (2) begin
      cmp(rd_gnt, 10'h100);
      cmp(addr_gnt, 10'h100);
      @(negedge mclk);
    end
    cmp(rd_gnt | addr_gnt, 10'h000);
  endtask : t_wait

  task automatic t_all;
    ur = '0;
    uw = '0;
    go(10'h3ff, 1'b0, 1'b0, 4'hf, 4'h0, 0, 0);
    repeat (12) begin
      cmp(wr_gnt & ~`SBA_DMA_WR_MASK, 10'h000);
      cmp(rd_gnt & `SBA_DMA_WR_MASK, 10'h000);
      ur = ur | rd_gnt;
      uw = uw | wr_gnt;
      @(negedge mclk);
    end
    cmp(ur, 10'h157);
    cmp(uw, 10'h2a8);
    cmp(rd_gnt | wr_gnt, 10'h000);
  endtask : t_all

  // Addressed write stalls one cycle; the addressed read must wait for the address path
  task automatic t_wait_write;
    go(10'h250, 1'b0, 1'b0, 4'h2, 4'h8, 0, 1);
    cmp(rd_gnt, 10'h040);
    cmp(wr_gnt, 10'h200);
    cmp(addr_gnt, 10'h200);
    cmp({9'h000, paired}, 10'h001);
    @(negedge mclk);
    cmp(wr_gnt, 10'h200);
    cmp(addr_gnt, 10'h200);
    cmp(rd_gnt, 10'h000);
    @(negedge mclk);
    cmp(rd_gnt, 10'h010);
    cmp(addr_gnt, 10'h010);
    cmp(wr_gnt, 10'h000);
    @(negedge mclk);
    cmp(rd_gnt | wr_gnt | addr_gnt, 10'h000);
  endtask : t_wait_write

  initial begin
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    cmp(rd_gnt | wr_gnt | addr_gnt, 10'h000);
    t_pair(10'h005, 1'b1, 1'b0, 10'h004, 10'h001, 10'h001);
    t_pair(10'h009, 1'b0, 1'b0, 10'h001, 10'h008, 10'h001);
    t_pair(10'h006, 1'b0, 1'b1, 10'h004, 10'h002, 10'h002);
    t_two_addressed();
    t_wait();
    t_all();
    t_wait_write();
    finish_test();
  end
endmodule : testbench
